// ### verilog/edcca_pkg.sv
// Purpose: Shared constants and carriers for the energy detect and channel assessment block
// Assumes: 50 MHz clock, AHB-Lite register access, 32-bit words
// Notes:   Symbol timing comes from a symbol strobe supplied by the modem
package edcca_pkg;

  // Register map (byte addresses)
  // Result register is a word index; its byte address is four times it
  localparam logic [7:0] EDCCA_ENERGY_RESULT_IDX = 8'h07;
  localparam logic [7:0] EDCCA_ENERGY_RESULT_OFS = EDCCA_ENERGY_RESULT_IDX << 2;
  localparam logic [7:0] EDCCA_CONTROL_OFS       = 8'h40;
  localparam logic [7:0] EDCCA_STATUS_OFS        = 8'h44;

  // Reset and range of the energy level code
  localparam logic [7:0] EDCCA_RESULT_RESET = 8'hFF;
  localparam logic [7:0] EDCCA_LEVEL_MAX    = 8'h54;

  // Control register fields
  localparam int EDCCA_CTL_MODE_LSB   = 0;
  localparam int EDCCA_CTL_HDR_BIT    = 2;
  localparam int EDCCA_CTL_PDT_DIS    = 3;
  localparam int EDCCA_CTL_THRES_LSB  = 4;
  localparam logic [7:0] EDCCA_CTL_RESET = 8'h01;

  // Measurement window in symbols
  localparam logic [3:0] EDCCA_SYM_STD = 4'h8;
  localparam logic [3:0] EDCCA_SYM_HDR = 4'h2;

  // Processing time after the window
  localparam int EDCCA_PROC_US     = 12;
  localparam int EDCCA_CLK_MHZ     = 50;
  localparam logic [9:0] EDCCA_PROC_CYC = 10'(EDCCA_PROC_US * EDCCA_CLK_MHZ);

  typedef enum logic [1:0] {
    EDCCA_IDLE = 2'b00,
    EDCCA_MEAS = 2'b01,
    EDCCA_PROC = 2'b11,
    EDCCA_HOLD = 2'b10
  } edcca_state_t;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
  } edcca_bus_t;

  typedef struct packed {
    edcca_state_t st;
    logic         manual;
    logic         auto_done;
    logic         locked;
    logic [3:0]   sym_cnt;
    logic [9:0]   proc_cnt;
    logic [9:0]   acc;
    logic [7:0]   result;
    logic [7:0]   ctl;
    logic         done_ev;
    edcca_bus_t   bus;
    logic [31:0]  rdata;
  } edcca_regs_t;

endpackage

// ### verilog/edcca_energy_detect.sv
// Contract
// - Energy is the average of strength samples over eight symbols at standard rates.
// - A write to the result register starts a manual measurement, data ignored.
// - A detected sync header starts an automatic measurement.
// - Manual end stores result and pulses the measurement done event.
// - Automatic measurement completion raises no done event.
// - Basic mode value ready eight symbols plus 12 us after frame start.
// - High data rate window is two symbols plus 12 us processing.
// - Stored value holds until a new frame start or a new measurement.
// - Captured frame value is not updated for the rest of that frame.
// - Energy code only ranges from zero to 0x54.
// - Result resets to 0xFF until a first measurement completes.
// - Code steps are 1.03 dB above floor; 84 means at least 87 dB.
// - Request outside receive or in auto-ack receive: done event, no measurement.
// - Preamble detect disable suppresses sync header detection.
// - Mode 1 reports busy when energy exceeds threshold.
// - Mode 2 reports busy only on a detected compliant carrier.
// - Mode 0 ORs, mode 3 ANDs carrier detection with energy over threshold.
// - Threshold is floor plus 2.07 dB per field step; above it is busy.
// - At most one automatic measurement per received frame.
//
// Purpose: Energy detection with clear channel decision, AHB-Lite registers
// Assumes: Strength samples are 5-bit codes of 3.1 dB, one sampled per symbol strobe
// Notes:   Inputs from the modem share this clock; no synchronisers are needed
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/100ps
module edcca_energy_detect
  import edcca_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Modem side
  input  wire logic        symbol_tick,
  input  wire logic [4:0]  rssi_sample,
  input  wire logic        sync_header_found,
  input  wire logic        frame_end_event,
  input  wire logic        carrier_detect,
  input  wire logic        rx_listen_state,
  input  wire logic        rx_busy_state,
  input  wire logic        auto_ack_receive_state,
  // Results
  output logic             measure_done_event,
  output logic             channel_busy,
  output logic             preamble_detect_disable
);

  edcca_regs_t q, d;

  // Strength code (3.1 dB) to energy code (1.03 dB), clipped at the top
  function automatic logic [7:0] edcca_level(input logic [9:0] sum, input logic [3:0] n);
    logic [13:0] scaled;
    logic [13:0] lvl;
    scaled = 14'(sum) * 14'd3;
    lvl    = (n == EDCCA_SYM_HDR) ? (scaled >> 1) : (scaled >> 3);
    edcca_level = (lvl > 14'(EDCCA_LEVEL_MAX)) ? EDCCA_LEVEL_MAX : lvl[7:0];
  endfunction

  logic       in_rx;
  logic       ok_rx;
  logic       wr_res;
  logic       start_auto;
  logic [3:0] win;
  logic [7:0] thres;
  logic       energy_hi;

  assign in_rx = rx_listen_state | rx_busy_state;
  assign ok_rx = in_rx & ~auto_ack_receive_state;
  assign wr_res = q.bus.sel & q.bus.write & (q.bus.addr == EDCCA_ENERGY_RESULT_OFS);
  assign start_auto = sync_header_found & ~q.ctl[EDCCA_CTL_PDT_DIS];
  assign win = q.ctl[EDCCA_CTL_HDR_BIT] ? EDCCA_SYM_HDR : EDCCA_SYM_STD;
  // threshold 2.07 dB steps equals two energy codes
  assign thres = {4'h0, q.ctl[7:EDCCA_CTL_THRES_LSB]} << 1;
  assign energy_hi = (q.result != EDCCA_RESULT_RESET) && (q.result > thres);

  always_comb begin
    d = q;
    d.done_ev = 1'b0;
    if (frame_end_event) begin
      d.locked    = 1'b0;
      d.auto_done = 1'b0;
    end
    // Bus address phase capture
    d.bus.sel   = hsel & hready & htrans[1];
    d.bus.write = hwrite;
    d.bus.addr  = haddr[7:0];
    d.rdata     = 32'h0000_0000;
    if (hsel & hready & htrans[1] & ~hwrite) begin
      case (haddr[7:0])
        EDCCA_ENERGY_RESULT_OFS: d.rdata = {24'h00_0000, q.result};
        EDCCA_CONTROL_OFS:       d.rdata = {24'h00_0000, q.ctl};
        EDCCA_STATUS_OFS:        d.rdata = {28'h000_0000, q.locked, q.manual,
                                            q.st != EDCCA_IDLE, channel_busy};
        default:                 d.rdata = 32'h0000_0000;
      endcase
    end
    if (q.bus.sel & q.bus.write & (q.bus.addr == EDCCA_CONTROL_OFS)) begin
      d.ctl = hwdata[7:0];
    end
    case (q.st)
      EDCCA_IDLE: begin
        if (start_auto && !q.auto_done) begin
          d.st = EDCCA_MEAS;
          d.manual = 1'b0;
          d.auto_done = 1'b1;
          d.sym_cnt = 4'h0;
          d.acc = 10'h000;
        end else if (wr_res) begin
          if (!ok_rx || q.locked) begin
            d.done_ev = 1'b1;
          end else begin
            d.st = EDCCA_MEAS;
            d.manual = 1'b1;
            d.sym_cnt = 4'h0;
            d.acc = 10'h000;
          end
        end
      end
      EDCCA_MEAS: begin
        if (symbol_tick) begin
          d.acc = q.acc + 10'(rssi_sample);
          d.sym_cnt = q.sym_cnt + 4'h1;
          // Ends even if the window shrinks mid-run
          if (q.sym_cnt + 4'h1 >= win) begin
            d.st = EDCCA_PROC;
            d.proc_cnt = EDCCA_PROC_CYC;
          end
        end
      end
      EDCCA_PROC: begin
        if (q.proc_cnt == 10'h001) begin
          d.st = EDCCA_IDLE;
          if (!(q.manual && q.locked)) begin
            d.result = edcca_level(q.acc, win);
          end
          // manual completion event, none for auto
          d.done_ev = q.manual;
          if (!q.manual) begin
            d.locked = 1'b1;
          end
        end else begin
          d.proc_cnt = q.proc_cnt - 10'h001;
        end
      end
      default: d.st = EDCCA_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= EDCCA_IDLE;
      q.result <= EDCCA_RESULT_RESET;
      q.ctl <= EDCCA_CTL_RESET;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    case (q.ctl[1:0])
      2'd1:    channel_busy = energy_hi;
      2'd2:    channel_busy = carrier_detect;
      2'd3:    channel_busy = carrier_detect & energy_hi;
      default: channel_busy = carrier_detect | energy_hi;
    endcase
  end

  assign hrdata                  = q.rdata;
  assign hreadyout               = 1'b1;
  assign hresp                   = 1'b0;
  assign measure_done_event      = q.done_ev;
  assign preamble_detect_disable = q.ctl[EDCCA_CTL_PDT_DIS];

  // Stored code never leaves the valid range after a measurement
  level_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(q.result) |-> q.result <= EDCCA_LEVEL_MAX)
    else $error("energy code out of range");

  // Auto completion produces no event
  auto_silent_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_PROC && q.proc_cnt == 10'h001 && !q.manual) |=> !measure_done_event)
    else $error("event on automatic measurement");

  // Manual completion raises the event next cycle
  manual_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_PROC && q.proc_cnt == 10'h001 && q.manual) |=> measure_done_event)
    else $error("missing done event");

  // Refused request still signals done
  refused_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_IDLE && wr_res && !start_auto && !ok_rx) |=> measure_done_event)
    else $error("refused request gave no event");

  // Result changes only at end of processing
  result_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(q.result) |-> $past(q.st) == EDCCA_PROC)
    else $error("result changed outside completion");

  // Sync ignored while detection disabled
  pdt_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_IDLE && !wr_res && q.ctl[EDCCA_CTL_PDT_DIS]) |=> q.st == EDCCA_IDLE)
    else $error("auto start while detection disabled");

  // Second sync in one frame is ignored
  one_auto_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_IDLE && q.auto_done && !frame_end_event && !wr_res) |=> q.st == EDCCA_IDLE)
    else $error("second automatic measurement");

  // Mode 1 follows energy only
  mode_one_a: assert property (@(posedge clk) disable iff (!rst_n)
    q.ctl[1:0] == 2'd1 |-> channel_busy == energy_hi)
    else $error("mode 1 decision wrong");

  // Processing lasts its full count
  proc_time_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_MEAS && d.st == EDCCA_PROC) |=> q.proc_cnt == EDCCA_PROC_CYC)
    else $error("processing count wrong");

  // Untouched code stays at the reset value
  reset_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.result == EDCCA_RESULT_RESET && q.st != EDCCA_PROC) |=> q.result == EDCCA_RESULT_RESET)
    else $error("reset code lost without measurement");

  // Result moves only when processing ends
  result_still_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st != EDCCA_PROC) |=> $stable(q.result))
    else $error("result changed outside processing");

  // No event during the window
  meas_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_MEAS) |=> !measure_done_event)
    else $error("event during measurement window");

  // No event before processing ends
  proc_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_PROC && q.proc_cnt != 10'h001) |=> !measure_done_event)
    else $error("event before processing ended");

  // Idle without request stays silent
  idle_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_IDLE && !wr_res) |=> !measure_done_event)
    else $error("spurious event while idle");

  // Automatic capture locks the frame
  auto_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_PROC && q.proc_cnt == 10'h001 && !q.manual) |=> q.locked)
    else $error("frame not locked after capture");

  // Locked frame refuses manual requests
  locked_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_IDLE && q.locked && wr_res && !start_auto) |=>
      (q.st == EDCCA_IDLE && measure_done_event))
    else $error("locked frame accepted a measurement");

  // Frame end releases the lock
  lock_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_end_event && q.st != EDCCA_PROC) |=> !q.locked)
    else $error("lock kept after frame end");

  // Frame end rearms automatic start
  frame_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_end_event && !start_auto) |=> !q.auto_done)
    else $error("automatic start not rearmed");

  // Sync header starts automatic run
  auto_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_IDLE && start_auto && !q.auto_done) |=> (q.st == EDCCA_MEAS && !q.manual))
    else $error("automatic measurement not started");

  // Accepted write starts manual run
  manual_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_IDLE && wr_res && ok_rx && !q.locked && !start_auto) |=>
      (q.st == EDCCA_MEAS && q.manual))
    else $error("manual measurement not started");

  // Auto-ack state performs no measurement
  aack_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_IDLE && wr_res && auto_ack_receive_state && !start_auto) |=>
      q.st == EDCCA_IDLE)
    else $error("measurement in auto-ack state");

  // Symbol count stays below the eight-symbol standard window
  sym_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_MEAS) |-> q.sym_cnt < EDCCA_SYM_STD)
    else $error("symbol count beyond window");

  // Eighth symbol closes the window
  long_window_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_MEAS && symbol_tick && q.sym_cnt == 4'h7) |=> q.st == EDCCA_PROC)
    else $error("window longer than eight symbols");

  // Sum holds between symbol strobes
  meas_stay_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_MEAS && !symbol_tick) |=> (q.st == EDCCA_MEAS && $stable(q.acc)))
    else $error("sum moved without a strobe");

  // Second symbol closes the short window
  short_window_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_MEAS && symbol_tick && q.sym_cnt == 4'h1 && q.ctl[EDCCA_CTL_HDR_BIT]) |=>
      q.st == EDCCA_PROC)
    else $error("short window not two symbols");

  // Processing count stays in range
  proc_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_PROC) |-> (q.proc_cnt != 10'h000 && q.proc_cnt <= EDCCA_PROC_CYC))
    else $error("processing count out of range");

  // Processing counts down one per cycle
  proc_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.st == EDCCA_PROC && q.proc_cnt != 10'h001) |=>
      (q.st == EDCCA_PROC && q.proc_cnt == $past(q.proc_cnt) - 10'h001))
    else $error("processing count skipped");

  // Stored code is valid or the reset code
  level_valid_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.result <= EDCCA_LEVEL_MAX) || (q.result == EDCCA_RESULT_RESET))
    else $error("stored code in forbidden range");

  // Mode 0 combines by OR
  mode_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    q.ctl[1:0] == 2'h0 |-> channel_busy == (carrier_detect || energy_hi))
    else $error("mode 0 decision wrong");

  // Mode 2 follows carrier only
  mode_two_a: assert property (@(posedge clk) disable iff (!rst_n)
    q.ctl[1:0] == 2'h2 |-> channel_busy == carrier_detect)
    else $error("mode 2 decision wrong");

  // Mode 3 combines by AND
  mode_three_a: assert property (@(posedge clk) disable iff (!rst_n)
    q.ctl[1:0] == 2'h3 |-> channel_busy == (carrier_detect && energy_hi))
    else $error("mode 3 decision wrong");

  // In mode 1, energy above twice the field is busy
  thres_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.ctl[1:0] == 2'h1 && q.result != EDCCA_RESULT_RESET &&
      q.result > {3'h0, q.ctl[7:4], 1'h0}) |-> channel_busy)
    else $error("energy above threshold not busy");

endmodule

// ### testbench/edcca_modem_model.sv
// Purpose: Modem side model giving symbol strobes and strength codes
// Assumes: Short symbol period keeps the run brief
// Notes:   Strength is only valid on the strobe; inverted otherwise
`timescale 1ns/100ps
module edcca_modem_model #(
  parameter int SYM_CYC = 4
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Strength to present
  input  wire logic [4:0] level,
  // Modem outputs
  output logic            symbol_tick,
  output logic      [4:0] rssi_sample
);
  logic [7:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= (cnt_q == 8'(SYM_CYC - 1)) ? 8'h00 : cnt_q + 8'h01;
    end
  end
  assign symbol_tick = (cnt_q == 8'(SYM_CYC - 1));
  // Stale strength would hide a wrong sampling moment
  assign rssi_sample = symbol_tick ? level : ~level;
endmodule

// ### testbench/edcca_energy_detect_tb_top.sv
// Purpose: Self-checking bench for the energy detect block
// Assumes: Zero wait AHB slave, one symbol every 4 clocks
// Notes:   Expected level is three times a constant strength code
`timescale 1ns/100ps
module edcca_energy_detect_tb_top import edcca_pkg::*;;
  logic        clk = 1'b0;
  logic        rst_n, hsel, hwrite, sync_hdr, frm_end, carrier;
  logic        listen, rxbusy, aack, tick, done, busy, pdd, hrdyo, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  lvl, rssi;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          n;
  logic        seen, e;

  always #10 clk = ~clk;

  edcca_modem_model #(.SYM_CYC(4)) model_u (.clk(clk), .rst_n(rst_n), .level(lvl),
    .symbol_tick(tick), .rssi_sample(rssi));

  edcca_energy_detect dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hrdyo), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hrdyo), .hresp(hresp), .symbol_tick(tick),
    .rssi_sample(rssi), .sync_header_found(sync_hdr), .frame_end_event(frm_end),
    .carrier_detect(carrier), .rx_listen_state(listen), .rx_busy_state(rxbusy),
    .auto_ack_receive_state(aack), .measure_done_event(done), .channel_busy(busy),
    .preamble_detect_disable(pdd));

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {24'h0000_00, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hrdyo !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hrdyo !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0000_0000, r);
    chk(r, exp);
  endtask

  // Cycles until the done pulse, then it must drop
  task automatic wait_done(output int k);
    k = 0;
    @(negedge clk);
    while (done !== 1'b1 && k < 1500) begin
      @(negedge clk);
      k++;
    end
    chk({31'h0, done}, 32'h0000_0001);
    @(negedge clk);
    chk({31'h0, done}, 32'h0000_0000);
    @(posedge clk);
  endtask

  task automatic quiet(input int k, output logic s);
    s = 1'b0;
    repeat (k) begin
      @(negedge clk);
      s = s | (done === 1'b1);
    end
    @(posedge clk);
  endtask

  task automatic pulse_sync();
    sync_hdr <= 1'b1;
    @(posedge clk);
    sync_hdr <= 1'b0;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    sync_hdr = 1'b0;
    frm_end = 1'b0;
    carrier = 1'b0;
    listen = 1'b1;
    rxbusy = 1'b0;
    aack = 1'b0;
    lvl = 5'd10;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(EDCCA_ENERGY_RESULT_OFS, 32'h0000_00FF);
    rd(EDCCA_CONTROL_OFS, 32'h0000_0001);
    rd(8'h80, 32'h0000_0000);
    // manual request in standard mode, data ignored
    wr(EDCCA_ENERGY_RESULT_OFS, 32'hDEAD_BEEF);
    chk({31'h0, hresp}, 32'h0000_0000);
    wait_done(n);
    chk(32'(n >= 625 && n < 1400), 32'h1);
    rd(EDCCA_ENERGY_RESULT_OFS, 32'h0000_001E);
    lvl <= 5'd28;
    wr(EDCCA_ENERGY_RESULT_OFS, 32'h0000_0000);
    wait_done(n);
    rd(EDCCA_ENERGY_RESULT_OFS, 32'h0000_0054);
    wr(EDCCA_CONTROL_OFS, 32'h0000_0005);
    lvl <= 5'd4;
    wr(EDCCA_ENERGY_RESULT_OFS, 32'h0000_0000);
    wait_done(n);
    chk(32'(n < 620), 32'h1);
    rd(EDCCA_ENERGY_RESULT_OFS, 32'h0000_000C);
    wr(EDCCA_CONTROL_OFS, 32'h0000_0001);
    for (int i = 0; i < 2; i++) begin
      listen <= i[0];
      aack   <= i[0];
      wr(EDCCA_ENERGY_RESULT_OFS, 32'h0000_0000);
      wait_done(n);
      chk(32'(n < 1400), 32'h1);
      rd(EDCCA_ENERGY_RESULT_OFS, 32'h0000_000C);
    end
    listen <= 1'b0;
    aack <= 1'b0;
    rxbusy <= 1'b1;
    lvl <= 5'd7;
    pulse_sync();
    quiet(700, seen);
    chk({31'h0, seen}, 32'h0000_0000);
    rd(EDCCA_ENERGY_RESULT_OFS, 32'h0000_0015);
    lvl <= 5'd2;
    wr(EDCCA_ENERGY_RESULT_OFS, 32'h0000_0000);
    wait_done(n);
    rd(EDCCA_ENERGY_RESULT_OFS, 32'h0000_0015);
    rd(EDCCA_STATUS_OFS, 32'h0000_0009);
    pulse_sync();
    quiet(700, seen);
    rd(EDCCA_ENERGY_RESULT_OFS, 32'h0000_0015);
    frm_end <= 1'b1;
    @(posedge clk);
    frm_end <= 1'b0;
    rxbusy <= 1'b0;
    listen <= 1'b1;
    rd(EDCCA_ENERGY_RESULT_OFS, 32'h0000_0015);
    wr(EDCCA_CONTROL_OFS, 32'h0000_0009);
    @(negedge clk);
    chk({31'h0, pdd}, 32'h0000_0001);
    @(posedge clk);
    pulse_sync();
    quiet(700, seen);
    rd(EDCCA_ENERGY_RESULT_OFS, 32'h0000_0015);
    for (int k = 0; k < 16; k++) begin
      wr(EDCCA_CONTROL_OFS, {24'h0, (k[3] ? 4'h5 : 4'hF), 2'b00, k[1:0]});
      carrier <= k[2];
      @(negedge clk);
      e = k[3];
      case (k[1:0])
        2'd0: chk({31'h0, busy}, {31'h0, e | k[2]});
        2'd1: chk({31'h0, busy}, {31'h0, e});
        2'd2: chk({31'h0, busy}, {31'h0, k[2]});
        default: chk({31'h0, busy}, {31'h0, e & k[2]});
      endcase
      @(posedge clk);
    end
    test_done();
  end
endmodule
